// ---- core/eac_cell_array.sv ----
`timescale 1ns/1ns
`default_nettype none

module eac_cell_array
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       ce,
    // Read port
    input  wire logic [5:0] rd_idx,
    output logic      [7:0] rd_byte,
    // Write port
    input  wire logic       wr_en,
    input  wire logic [5:0] wr_idx,
    input  wire logic [7:0] wr_byte
);

    logic [7:0] mem_ff [eac_pkg::ARRAY_DEPTH];

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < eac_pkg::ARRAY_DEPTH; i++)
            begin
                mem_ff[i] <= eac_pkg::CELL_ERASE;
            end
        end
        else if (ce && wr_en)
        begin
            mem_ff[wr_idx] <= wr_byte;
        end
    end

    assign rd_byte = mem_ff[rd_idx];

endmodule : eac_cell_array

`default_nettype wire

// ---- core/eac_pkg.sv ----
`default_nettype none

package eac_pkg;

    // Register offsets
    localparam logic [7:0] OFF_DATA  = 8'h08;
    localparam logic [7:0] OFF_ADDR  = 8'h09;
    localparam logic [7:0] OFF_CTRL  = 8'h88;
    localparam logic [7:0] OFF_KEY   = 8'h89;

    // Control register field positions
    localparam int BIT_RD    = 0;
    localparam int BIT_WR    = 1;
    localparam int BIT_WRITE_ENABLE_BIT  = 2;
    localparam int BIT_WERR  = 3;
    localparam int BIT_DONE  = 4;
    localparam int CTRL_BITS = 5;

    // Reset values
    localparam logic [7:0] DATA_RST   = 8'h00;
    localparam logic [7:0] ADDR_RST   = 8'h00;
    localparam logic [7:0] CELL_ERASE = 8'hFF;
    localparam logic [7:0] READ_ZERO  = 8'h00;

    // Unlock key bytes
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    // Array geometry
    localparam int ARRAY_DEPTH = 64;
    localparam int IDX_W       = 6;

    // Power-up hold-off
    localparam int CLK_HZ         = 125_000_000;
    localparam int POWER_UP_DELAY_TIMER_MS        = 72;
    localparam int POWER_UP_DELAY_TIMER_CYCLES    = POWER_UP_DELAY_TIMER_MS * (CLK_HZ / 1000);
    localparam int POWER_UP_DELAY_TIMER_CNT_W     = 24;

    // Write cycle length in clock cycles
    localparam int WRITE_CYCLES   = 2000;
    localparam int WCNT_W         = 16;

    // Address lies inside the implemented array
    function automatic logic idx_ok(input logic [7:0] addr);
        idx_ok = (addr[7:IDX_W] == 2'b00);
    endfunction : idx_ok

endpackage : eac_pkg

`default_nettype wire

// ---- core/eac_top.sv ----
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Control register has five bits; upper three read as zero.
// - Software can set read and write start bits but never clear them.
// - Hardware clears read start after read, write start after write cycle.
// - Power-up forces write enable to zero.
// - External or watchdog reset during a write sets the abort error bit.
// - Data and address registers keep their values across such a reset.
// - Write completion sets the done flag; only software or a power-on, external or watchdog reset clears it.
// - Unlock port stores nothing, reads zero, writes only advance the key.
// - Read start loads data register from array, valid next cycle.
// - Data register holds a read value until next read or software write.
// - Write starts only after 55h, AAh to unlock port, then write start.
// - Write start is blocked while write enable is zero.
// - Hardware never clears write enable by itself.
// - Clearing write enable during a write leaves the cycle untouched.
// - Done flag serves as pollable status and as interrupt request.
// - Writes are refused while the power-up hold-off timer runs.
// - Code protection does not affect plain CPU reads and writes.
// - Array holds 64 bytes; address upper two bits must be zero.
// - Each byte write erases the location before programming it.
// - An internal timer sets each write cycle's duration.

module eac_top
#(
    parameter int POWER_UP_DELAY_TIMER_CYCLES  = eac_pkg::POWER_UP_DELAY_TIMER_CYCLES,
    parameter int WRITE_CYCLES = eac_pkg::WRITE_CYCLES
)
(
    // Clock, reset, enable
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       ce,
    // Non-power-on resets
    input  wire logic       ext_reset_req,
    input  wire logic       wdt_reset_req,
    // Register port
    input  wire logic [7:0] cpu_addr,
    input  wire logic       cpu_wr,
    input  wire logic       cpu_rd,
    input  wire logic [7:0] cpu_wdata,
    output logic      [7:0] cpu_rdata,
    // Status
    output logic            program_done_flag,
    output logic            write_busy
);

    // Control register bits
    logic                          rd_go_ff;
    logic                          wr_go_ff;
    logic                          write_enable_bit_ff;
    logic                          werr_ff;
    logic                          done_ff;
    // Data path registers
    logic [7:0]                    data_ff;
    logic [7:0]                    addr_ff;
    logic [7:0]                    wlat_addr_ff;
    logic [7:0]                    wlat_data_ff;
    logic [7:0]                    rdata_ff;
    // Timers
    logic [eac_pkg::WCNT_W-1:0]    wcnt_ff;
    logic [eac_pkg::POWER_UP_DELAY_TIMER_CNT_W-1:0] power_up_delay_timer_cnt_ff;
    logic                          power_up_delay_timer_done_ff;

    logic       soft_rst;
    logic       acc;
    logic       wr_data;
    logic       wr_addr;
    logic       wr_ctrl;
    logic       wr_key;
    logic       armed;
    logic       start_wr;
    logic       wr_finish;
    logic [7:0] rd_byte;
    logic [7:0] rd_val;
    logic [7:0] ctrl_view;
    logic       arr_wr_en;
    logic [5:0] arr_wr_idx;
    logic [7:0] arr_wr_byte;

    assign soft_rst = ext_reset_req | wdt_reset_req;
    assign acc      = cpu_wr | cpu_rd;
    assign wr_data  = cpu_wr && cpu_addr == eac_pkg::OFF_DATA;
    assign wr_addr  = cpu_wr && cpu_addr == eac_pkg::OFF_ADDR;
    assign wr_ctrl  = cpu_wr && cpu_addr == eac_pkg::OFF_CTRL;
    assign wr_key   = cpu_wr && cpu_addr == eac_pkg::OFF_KEY;

    // Write start qualification
    assign start_wr = wr_ctrl && cpu_wdata[eac_pkg::BIT_WR] && !wr_go_ff
                      && write_enable_bit_ff
                      && armed
                      && power_up_delay_timer_done_ff
                      && !soft_rst;

    assign wr_finish = wr_go_ff && wcnt_ff == '0 && !soft_rst;

    // Out-of-range addresses read as zero
    assign rd_val = eac_pkg::idx_ok(addr_ff) ? rd_byte : eac_pkg::READ_ZERO;

    assign ctrl_view = {3'b000, done_ff, werr_ff, write_enable_bit_ff, wr_go_ff, rd_go_ff};

    eac_unlock u_unlock
    (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .clr      (soft_rst),
        .acc      (acc),
        .key_wr   (wr_key),
        .key_data (cpu_wdata),
        .armed    (armed)
    );

    // Erase at start, program at finish
    always_comb
    begin
        arr_wr_en   = 1'b0;
        arr_wr_idx  = wlat_addr_ff[5:0];
        arr_wr_byte = wlat_data_ff;
        if (start_wr && eac_pkg::idx_ok(addr_ff))
        begin
            arr_wr_en   = 1'b1;
            arr_wr_idx  = addr_ff[5:0];
            arr_wr_byte = eac_pkg::CELL_ERASE;
        end
        else if (wr_finish && eac_pkg::idx_ok(wlat_addr_ff))
        begin
            arr_wr_en   = 1'b1;
        end
    end

    eac_cell_array u_array
    (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .rd_idx  (addr_ff[5:0]),
        .rd_byte (rd_byte),
        .wr_en   (arr_wr_en),
        .wr_idx  (arr_wr_idx),
        .wr_byte (arr_wr_byte)
    );

    // Power-up hold-off timer
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            power_up_delay_timer_cnt_ff  <= '0;
            power_up_delay_timer_done_ff <= 1'b0;
        end
        else if (ce && !power_up_delay_timer_done_ff)
        begin
            if (power_up_delay_timer_cnt_ff == eac_pkg::POWER_UP_DELAY_TIMER_CNT_W'(POWER_UP_DELAY_TIMER_CYCLES - 1))
                power_up_delay_timer_done_ff <= 1'b1;
            else
                power_up_delay_timer_cnt_ff <= power_up_delay_timer_cnt_ff + 1'b1;
        end
    end

    // Read start bit
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            rd_go_ff <= 1'b0;
        else if (ce)
        begin
            if (soft_rst)
                rd_go_ff <= 1'b0;
            else if (rd_go_ff)
                rd_go_ff <= 1'b0;
            else if (wr_ctrl && cpu_wdata[eac_pkg::BIT_RD])
                rd_go_ff <= 1'b1;
        end
    end

    // Write start bit and write cycle timer
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_go_ff     <= 1'b0;
            wcnt_ff      <= '0;
            wlat_addr_ff <= eac_pkg::ADDR_RST;
            wlat_data_ff <= eac_pkg::DATA_RST;
        end
        else if (ce)
        begin
            if (soft_rst)
                wr_go_ff <= 1'b0;
            else if (start_wr)
            begin
                wr_go_ff     <= 1'b1;
                wcnt_ff      <= eac_pkg::WCNT_W'(WRITE_CYCLES - 1);
                wlat_addr_ff <= addr_ff;
                wlat_data_ff <= data_ff;
            end
            else if (wr_finish)
                wr_go_ff <= 1'b0;
            else if (wr_go_ff)
                wcnt_ff <= wcnt_ff - 1'b1;
        end
    end

    // Write enable: software only
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            write_enable_bit_ff <= 1'b0;
        else if (ce)
        begin
            if (soft_rst)
                write_enable_bit_ff <= 1'b0;
            else if (wr_ctrl)
                write_enable_bit_ff <= cpu_wdata[eac_pkg::BIT_WRITE_ENABLE_BIT];
        end
    end

    // Abort error bit
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            werr_ff <= 1'b0;
        else if (ce)
        begin
            if (soft_rst && wr_go_ff)
                werr_ff <= 1'b1;
            else if (wr_ctrl && !soft_rst)
                werr_ff <= cpu_wdata[eac_pkg::BIT_WERR];
        end
    end

    // Done flag, set beats clear
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            done_ff <= 1'b0;
        else if (ce)
        begin
            if (soft_rst)
                done_ff <= 1'b0;
            else if (wr_finish)
                done_ff <= 1'b1;
            else if (wr_ctrl)
                done_ff <= cpu_wdata[eac_pkg::BIT_DONE];
        end
    end

    // Address register survives non-power-on resets
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            addr_ff <= eac_pkg::ADDR_RST;
        else if (ce && wr_addr)
            addr_ff <= cpu_wdata;
    end

    // Data register: read load beats software write
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            data_ff <= eac_pkg::DATA_RST;
        else if (ce)
        begin
            if (rd_go_ff && !soft_rst)
                data_ff <= rd_val;
            else if (wr_data)
                data_ff <= cpu_wdata;
        end
    end

    // Read data return
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            rdata_ff <= eac_pkg::READ_ZERO;
        else if (ce && cpu_rd)
        begin
            unique case (cpu_addr)
                eac_pkg::OFF_DATA: rdata_ff <= data_ff;
                eac_pkg::OFF_ADDR: rdata_ff <= addr_ff;
                eac_pkg::OFF_CTRL: rdata_ff <= ctrl_view;
                default:           rdata_ff <= eac_pkg::READ_ZERO;
            endcase
        end
    end

    assign cpu_rdata         = rdata_ff;
    assign program_done_flag = done_ff;
    assign write_busy        = wr_go_ff;

    ctrl_upper_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (ce && cpu_rd && cpu_addr == eac_pkg::OFF_CTRL)
        |=> cpu_rdata[7:eac_pkg::CTRL_BITS] == 3'b000
            && cpu_rdata[eac_pkg::BIT_WR] == $past(wr_go_ff))
        else $error("control read shows wrong upper bits or write state");

    key_read_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (ce && cpu_rd && cpu_addr == eac_pkg::OFF_KEY) |=> cpu_rdata == 8'h00)
        else $error("unlock port read not zero");

    go_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (wr_go_ff && wcnt_ff != '0 && !soft_rst) |=> wr_go_ff)
        else $error("write start bit dropped before cycle end");

    start_needs_write_enable_bit_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(wr_go_ff) |-> $past(write_enable_bit_ff) && $past(armed) && $past(power_up_delay_timer_done_ff))
        else $error("write started without enable, key or hold-off end");

    write_done_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (ce && wr_finish) |=> done_ff && !wr_go_ff)
        else $error("write end did not set done and clear start");

    done_sticky_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (done_ff && !soft_rst && !(wr_ctrl && !cpu_wdata[eac_pkg::BIT_DONE])) |=> done_ff)
        else $error("done flag cleared by hardware");

    abort_err_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (ce && soft_rst && wr_go_ff) |=> werr_ff && !wr_go_ff && $stable(addr_ff))
        else $error("aborted write not flagged");

    read_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (ce && rd_go_ff && !soft_rst) |=> data_ff == $past(rd_val) && !rd_go_ff)
        else $error("read did not load data register");

    write_enable_bit_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (write_enable_bit_ff && !soft_rst && !wr_ctrl) |=> write_enable_bit_ff)
        else $error("write enable cleared by hardware");

    write_enable_bit_clear_keeps_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (ce && wr_go_ff && wcnt_ff != '0 && !soft_rst && wr_ctrl
         && !cpu_wdata[eac_pkg::BIT_WRITE_ENABLE_BIT]) |=> wr_go_ff)
        else $error("clearing write enable stopped the write");

    abort_keeps_data_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (ce && soft_rst && !wr_data) |=> $stable(data_ff))
        else $error("data register changed on abort reset");

endmodule : eac_top

`default_nettype wire

// ---- core/eac_unlock.sv ----
`timescale 1ns/1ns
`default_nettype none

module eac_unlock
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       ce,
    input  wire logic       clr,
    // Register access view
    input  wire logic       acc,
    input  wire logic       key_wr,
    input  wire logic [7:0] key_data,
    // Status
    output logic            armed
);

    typedef enum logic [1:0] {ST_IDLE, ST_FIRST, ST_ARMED} eac_unlock_st_t;

    eac_unlock_st_t state_ff;
    eac_unlock_st_t nxt_state;

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE:
            begin
                if (key_wr && key_data == eac_pkg::KEY_FIRST)
                    nxt_state = ST_FIRST;
            end
            ST_FIRST:
            begin
                if (key_wr && key_data == eac_pkg::KEY_SECOND)
                    nxt_state = ST_ARMED;
                else if (acc)
                    nxt_state = ST_IDLE;
            end
            ST_ARMED:
            begin
                // Next access either uses or breaks the key
                if (acc)
                    nxt_state = ST_IDLE;
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            state_ff <= ST_IDLE;
        else if (ce)
            state_ff <= clr ? ST_IDLE : nxt_state;
    end

    assign armed = (state_ff == ST_ARMED);

    arm_order_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (ce && !clr && state_ff == ST_FIRST && !(key_wr && key_data == eac_pkg::KEY_SECOND)
         && acc) |=> state_ff == ST_IDLE)
        else $error("unlock tracker kept state after broken order");

endmodule : eac_unlock

`default_nettype wire

// ---- test/data_eeprom_access_controller_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none

module data_eeprom_access_controller_tb_top;
    localparam int POWER_UP_DELAY_TIMER = 20;
    localparam int WCYC = 10;

    logic       sys_clk       = 1'b0;
    logic       sys_rst       = 1'b1;
    logic       ce            = 1'b1;
    logic       ext_reset_req = 1'b0;
    logic       wdt_reset_req = 1'b0;
    logic [7:0] cpu_addr      = 8'h00;
    logic       cpu_wr        = 1'b0;
    logic       cpu_rd        = 1'b0;
    logic [7:0] cpu_wdata     = 8'h00;
    logic [7:0] cpu_rdata;
    logic       program_done_flag;
    logic       write_busy;
    logic       upd           = 1'b0;
    logic [5:0] upd_idx       = 6'h00;
    logic [7:0] upd_byte      = 8'h00;
    logic [5:0] look_idx      = 6'h00;
    logic [7:0] look_byte;
    logic [7:0] q;
    int         mismatches    = 0;
    int         comparisons   = 0;

    eac_top #(.POWER_UP_DELAY_TIMER_CYCLES(POWER_UP_DELAY_TIMER), .WRITE_CYCLES(WCYC)) i_dut
    (
        .sys_clk           (sys_clk),
        .sys_rst           (sys_rst),
        .ce                (ce),
        .ext_reset_req     (ext_reset_req),
        .wdt_reset_req     (wdt_reset_req),
        .cpu_addr          (cpu_addr),
        .cpu_wr            (cpu_wr),
        .cpu_rd            (cpu_rd),
        .cpu_wdata         (cpu_wdata),
        .cpu_rdata         (cpu_rdata),
        .program_done_flag (program_done_flag),
        .write_busy        (write_busy)
    );

    eac_ee_model i_model
    (
        .sys_clk   (sys_clk),
        .upd       (upd),
        .upd_idx   (upd_idx),
        .upd_byte  (upd_byte),
        .look_idx  (look_idx),
        .look_byte (look_byte)
    );

    initial
    begin
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic complete_run;
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        cpu_addr  <= a;
        cpu_wdata <= d;
        cpu_wr    <= 1'b1;
        @(posedge sys_clk);
        cpu_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        cpu_addr <= a;
        cpu_rd   <= 1'b1;
        @(posedge sys_clk);
        cpu_rd   <= 1'b0;
        @(posedge sys_clk);
        #1;
        q = cpu_rdata;
    endtask : rd

    task automatic write_byte(input logic [5:0] a, input logic [7:0] d);
        wr(eac_pkg::OFF_DATA, d);
        wr(eac_pkg::OFF_ADDR, {2'b00, a});
        wr(eac_pkg::OFF_CTRL, 8'h04);
        // Key and start back to back, nothing may interleave
        wr(eac_pkg::OFF_KEY, 8'h55);
        wr(eac_pkg::OFF_KEY, 8'hAA);
        wr(eac_pkg::OFF_CTRL, 8'h06);
    endtask : write_byte

    task automatic ee_read(input logic [7:0] a);
        wr(eac_pkg::OFF_ADDR, a);
        wr(eac_pkg::OFF_CTRL, 8'h01);
        rd(eac_pkg::OFF_DATA);
    endtask : ee_read

    task automatic expect_cell(input logic [5:0] a);
        ee_read({2'b00, a});
        look_idx = a;
        #1;
        chk("cell byte", look_byte, q);
    endtask : expect_cell

    task automatic mdl(input logic [5:0] a, input logic [7:0] d);
        upd      <= 1'b1;
        upd_idx  <= a;
        upd_byte <= d;
        @(posedge sys_clk);
        upd      <= 1'b0;
    endtask : mdl

    task automatic wait_idle;
        for (int i = 0; i < 100; i++)
        begin
            @(posedge sys_clk);
            #1;
            if (write_busy === 1'b0)
                return;
        end
        mismatches++;
        complete_run();
    endtask : wait_idle

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        complete_run();
    end

    initial
    begin
        int n;
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(eac_pkg::OFF_CTRL);
        chk("ctrl after power-up", 8'h00, q);
        write_byte(6'h01, 8'h3C);
        #1;
        chk("busy in hold-off", 8'h00, {7'h00, write_busy});
        $display("test power-up done");

        repeat (POWER_UP_DELAY_TIMER) @(posedge sys_clk);
        write_byte(6'h03, 8'h5A);
        n = 0;
        for (int i = 0; i < 200; i++)
        begin
            #1;
            if (write_busy === 1'b1)
                n++;
            else if (n > 0)
                break;
            @(posedge sys_clk);
        end
        chk("busy cycles", WCYC[7:0], n[7:0]);
        mdl(6'h03, 8'h5A);
        repeat (5) @(posedge sys_clk);
        rd(eac_pkg::OFF_CTRL);
        chk("ctrl after write", 8'h14, q);
        chk("done port", 8'h01, {7'h00, program_done_flag});
        expect_cell(6'h03);
        rd(eac_pkg::OFF_CTRL);
        chk("ctrl after read", 8'h00, q);
        wr(eac_pkg::OFF_ADDR, 8'h3F);
        rd(eac_pkg::OFF_DATA);
        chk("data held", 8'h5A, q);
        $display("test write and read done");

        write_byte(6'h3F, 8'hC3);
        repeat (2) @(posedge sys_clk);
        wr(eac_pkg::OFF_CTRL, 8'h00);
        #1;
        chk("busy after clear", 8'h01, {7'h00, write_busy});
        rd(eac_pkg::OFF_CTRL);
        chk("ctrl in write", 8'h02, q);
        wait_idle();
        mdl(6'h3F, 8'hC3);
        #1;
        chk("done set", 8'h01, {7'h00, program_done_flag});
        wr(eac_pkg::OFF_CTRL, 8'h00);
        #1;
        chk("done cleared", 8'h00, {7'h00, program_done_flag});
        expect_cell(6'h3F);
        $display("test write protect done");

        wr(eac_pkg::OFF_DATA, 8'h00);
        wr(eac_pkg::OFF_ADDR, 8'h03);
        for (int v = 0; v < 4; v++)
        begin
            wr(eac_pkg::OFF_CTRL, (v == 0) ? 8'h00 : 8'h04);
            wr(eac_pkg::OFF_KEY, (v == 3) ? 8'hAA : 8'h55);
            if (v == 2)
                rd(eac_pkg::OFF_DATA);
            wr(eac_pkg::OFF_KEY, (v == 1) ? 8'hAB : ((v == 3) ? 8'h55 : 8'hAA));
            wr(eac_pkg::OFF_CTRL, 8'h06);
            #1;
            chk("busy on bad start", 8'h00, {7'h00, write_busy});
        end
        expect_cell(6'h03);
        $display("test refused starts done");

        for (int k = 0; k < 2; k++)
        begin
            write_byte(6'h07, 8'h11 + k[7:0]);
            repeat (3) @(posedge sys_clk);
            ext_reset_req <= (k == 0);
            wdt_reset_req <= (k == 1);
            @(posedge sys_clk);
            ext_reset_req <= 1'b0;
            wdt_reset_req <= 1'b0;
            #1;
            chk("busy after abort", 8'h00, {7'h00, write_busy});
            mdl(6'h07, 8'hFF);
            rd(eac_pkg::OFF_CTRL);
            chk("ctrl after abort", 8'h08, q);
            rd(eac_pkg::OFF_DATA);
            chk("data after abort", 8'h11 + k[7:0], q);
            rd(eac_pkg::OFF_ADDR);
            chk("addr after abort", 8'h07, q);
            expect_cell(6'h07);
        end
        $display("test aborts done");

        wr(eac_pkg::OFF_CTRL, 8'hE0);
        rd(eac_pkg::OFF_CTRL);
        chk("ctrl upper bits", 8'h00, q);
        wr(eac_pkg::OFF_KEY, 8'h5A);
        rd(eac_pkg::OFF_KEY);
        chk("unlock port", 8'h00, q);
        rd(8'h40);
        chk("unmapped read", 8'h00, q);
        ee_read(8'h43);
        chk("out of range", 8'h00, q);
        ce <= 1'b0;
        wr(eac_pkg::OFF_DATA, 8'h77);
        ce <= 1'b1;
        rd(eac_pkg::OFF_DATA);
        chk("data while frozen", 8'h00, q);
        $display("test reads done");
        complete_run();
    end
endmodule : data_eeprom_access_controller_tb_top

`default_nettype wire

// ---- test/eac_ee_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module eac_ee_model
(
    // Clock
    input  wire logic       sys_clk,
    // Cell update from the bench
    input  wire logic       upd,
    input  wire logic [5:0] upd_idx,
    input  wire logic [7:0] upd_byte,
    // Cell lookup
    input  wire logic [5:0] look_idx,
    output logic      [7:0] look_byte
);
    logic [7:0] cell_ff [0:63];

    // Cells start erased
    initial
    begin
        for (int i = 0; i < 64; i++)
        begin
            cell_ff[i] = 8'hFF;
        end
    end

    // Erased or programmed byte after a cycle or an abort
    always @(posedge sys_clk)
    begin
        if (upd)
            cell_ff[upd_idx] <= upd_byte;
    end

    assign look_byte = cell_ff[look_idx];
endmodule : eac_ee_model

`default_nettype wire
